//--- logic/ssp_params.svh
// Register map, field positions, reset values and timing counts
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
`define SSP_AW 12
`define SSP_OFF_CTL 12'h000
`define SSP_OFF_STAT 12'h004
`define SSP_OFF_BUF 12'h008
`define SSP_CTL_WRITE_COLLISION_FLAG 7
`define SSP_CTL_OV 6
`define SSP_CTL_EN 5
`define SSP_CTL_CKP 4
`define SSP_CTL_MODE 3:0
`define SSP_STAT_SMP 7
`define SSP_STAT_CKE 6
`define SSP_STAT_BF 0
`define SSP_CTL_RST 8'h00
`define SSP_STAT_RST 8'h00
`define SSP_MODE_M4 4'h0
`define SSP_MODE_M16 4'h1
`define SSP_MODE_M64 4'h2
`define SSP_MODE_MT2 4'h3
`define SSP_MODE_SSS 4'h4
`define SSP_MODE_SNS 4'h5
`define SSP_HALF_M4 6'h01
`define SSP_HALF_M16 6'h07
`define SSP_HALF_M64 6'h1F
`define SSP_TICKS 5'h10
`define SSP_LAST_TICK_LEAD 5'h0F
`define SSP_LAST_TICK_TRAIL 5'h10
`define SSP_LAST_BIT 3'h7
`define SSP_SYNC_RST 3'h4
`define SSP_SDI_LAT 4
`endif

//--- logic/ssp_pkg.sv
// Shared types of the serial port
package ssp_pkg;
   typedef logic [31:0] ssp_word_t;
   typedef logic [7:0] ssp_byte_t;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_SHIFT = 3'b100
   } ssp_state_t;
endpackage : ssp_pkg

//--- logic/ssp_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ssp_sync3
#(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   import ssp_pkg::*;
   logic [W-1:0] s1_r, s2_r, s3_r, q_r, q_nxt;

   if (W < 1)
   begin : g_chk
      $error("W must be at least 1");
   end

   always_comb
   begin
      q_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & q_r);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
         q_r <= RST_VAL;
      end
      else
      begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r <= q_nxt;
      end
   end

   assign q = q_r;
endmodule : ssp_sync3
`default_nettype wire

//--- logic/ssp_skid2.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ssp_skid2
#(
   parameter int W = 8
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   import ssp_pkg::*;
   localparam logic [1:0] FULL = 2'h2;
   logic [W-1:0] mem_r [2];
   logic [W-1:0] mem_nxt [2];
   logic wp_r, wp_nxt, rp_r, rp_nxt, push, pop;
   logic [1:0] cnt_r, cnt_nxt;

   if (W < 1)
   begin : g_chk
      $error("W must be at least 1");
   end

   always_comb
   begin
      push = in_valid && (cnt_r != FULL);
      pop = out_ready && (cnt_r != 2'h0);
      mem_nxt = mem_r;
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      if (push)
      begin
         mem_nxt[wp_r] = in_data;
         wp_nxt = !wp_r;
      end
      if (pop)
         rp_nxt = !rp_r;
      cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk)
   begin
      mem_r <= mem_nxt;
      if (rst)
      begin
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
      end
      else
      begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign in_ready = (cnt_r != FULL);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data = mem_r[rp_r];
endmodule : ssp_skid2
`default_nettype wire

//--- logic/ssp_spi.sv
// SPI-mode synchronous serial port with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "ssp_params.svh"
// What this block does
// - Buffer write while a word shifts sets the collision flag until software clears it
// - Slave byte completing while buffer unread sets overflow and the new byte is dropped
// - Overflow flag is set only in slave operation
// - Master transfer starts only on a software write to the buffer
// - Port enable gives the clock, data-out and data-in pins to the port
// - Idle polarity bit sets the resting serial clock level
// - Modes 0 to 2 divide the clock by 4, 16, 64; mode 3 uses timer ticks
// - Mode 4 is slave clocked by the pin with slave select active
// - Mode 5 is slave clocked by the pin, slave select ignored
// - Master samples input at end of output time if phase bit set, else middle
// - Clock edge bit picks the edge where data is stable, mirrored by polarity
// - Buffer-full reads one when a received byte waits, zero when empty
// - Reading the buffer clears buffer-full
// - After eight bits the byte loads, buffer-full sets and the port flag pulses
// - Shifting is most significant bit first
// - Slave select high holds a mode 4 slave in reset, clears bit count, releases data-out
module ssp_spi
#(
   parameter int DATA_W = 8
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`SSP_AW-1:0] paddr,
   input wire ssp_pkg::ssp_word_t pwdata,
   output logic pready,
   output ssp_pkg::ssp_word_t prdata,
   output logic pslverr,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   input wire logic sdi_in,
   output logic sdo_out,
   output logic sdo_oe,
   input wire logic ss_n_in,
   input wire logic timer_two_tick,
   output logic port_pins_owned,
   output logic port_interrupt_flag
);
   import ssp_pkg::*;

   if (DATA_W != 8)
   begin : g_chk
      $error("DATA_W must be 8");
   end

   logic [7:0] ctl_r, ctl_nxt, xbuf_r, xbuf_nxt, shreg_r, shreg_nxt, stat_rd;
   logic smp_r, smp_nxt, cke_r, cke_nxt, bf_r, bf_nxt;
   logic sck_r, sck_nxt, sdo_r, sdo_nxt, sck_oe_r, sck_oe_nxt, sdo_oe_r, sdo_oe_nxt;
   logic own_r, own_nxt, irq_r, irq_nxt, sck_q_r, sck_q_nxt;
   ssp_state_t state_r, state_nxt;
   logic [4:0] tick_cnt_r, tick_cnt_nxt, last_tick;
   logic [5:0] div_r, div_nxt, half;
   logic [2:0] bitcnt_r, bitcnt_nxt, pins_s;
   logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
   ssp_word_t prdata_r, prdata_nxt;
   logic sck_s, sdi_s, ssn_s, in_valid, in_ready, out_valid, out_ready;
   logic [7:0] in_data, out_data;
   logic en, clock_idle_polarity, master, slave, ss_hold, busy, tick, sedge, lead, stable;
   logic setup, acc, wr_ctl, wr_stat, wr_buf, rd_buf, mapped;
   logic [`SSP_SDI_LAT-1:0] msh_r, msh_nxt, mov_r, mov_nxt, mdone_r, mdone_nxt;
   logic [7:0] mrx_r, mrx_nxt;
   localparam logic [7:0] STAT_RST = `SSP_STAT_RST;

   function automatic logic mode_master(input logic [3:0] m);
      mode_master = (m <= `SSP_MODE_MT2);
   endfunction : mode_master

   function automatic logic addr_is(input logic [`SSP_AW-1:0] a,
                                    input logic [`SSP_AW-1:0] off);
      addr_is = (a == off);
   endfunction : addr_is

   ssp_sync3 #(.W(3), .RST_VAL(`SSP_SYNC_RST)) u_sync
   (
      .clk(clk),
      .rst(rst),
      .d({ss_n_in, sdi_in, sck_in}),
      .q(pins_s)
   );

   ssp_skid2 #(.W(DATA_W)) u_rxbuf
   (
      .clk(clk),
      .rst(rst),
      .in_valid(in_valid),
      .in_ready(in_ready),
      .in_data(in_data),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_data)
   );

   assign {ssn_s, sdi_s, sck_s} = pins_s;
   assign en = ctl_r[`SSP_CTL_EN];
   assign clock_idle_polarity = ctl_r[`SSP_CTL_CKP];
   assign master = en && mode_master(ctl_r[`SSP_CTL_MODE]);
   assign slave = en && (ctl_r[`SSP_CTL_MODE] == `SSP_MODE_SSS ||
                         ctl_r[`SSP_CTL_MODE] == `SSP_MODE_SNS);
   // Only mode 4 listens to slave select
   assign ss_hold = slave && ctl_r[`SSP_CTL_MODE] == `SSP_MODE_SSS && ssn_s;
   assign busy = master ? (state_r != ST_IDLE || mdone_r != '0) : (bitcnt_r != 3'h0);

   assign setup = psel && !penable;
   assign acc = psel && penable && pready_r;
   assign mapped = addr_is(paddr, `SSP_OFF_CTL) || addr_is(paddr, `SSP_OFF_STAT) ||
                   addr_is(paddr, `SSP_OFF_BUF);
   assign wr_ctl = acc && pwrite && addr_is(paddr, `SSP_OFF_CTL);
   assign wr_stat = acc && pwrite && addr_is(paddr, `SSP_OFF_STAT);
   assign wr_buf = acc && pwrite && addr_is(paddr, `SSP_OFF_BUF);
   assign rd_buf = acc && !pwrite && addr_is(paddr, `SSP_OFF_BUF);
   // Hold the receive buffer while software reads it
   assign out_ready = !(psel && !pwrite && addr_is(paddr, `SSP_OFF_BUF));

   // Bit clock source per mode
   always_comb
   begin
      case (ctl_r[`SSP_CTL_MODE])
         `SSP_MODE_M16: half = `SSP_HALF_M16;
         `SSP_MODE_M64: half = `SSP_HALF_M64;
         default: half = `SSP_HALF_M4;
      endcase
   end

   assign tick = (state_r == ST_SHIFT) && ((ctl_r[`SSP_CTL_MODE] == `SSP_MODE_MT2) ?
                 timer_two_tick : (div_r == half));
   assign sedge = sck_s != sck_q_r;
   assign lead = master ? (sck_r == clock_idle_polarity) : (sck_s != clock_idle_polarity);
   assign stable = cke_r ? lead : !lead;
   assign last_tick = cke_r ? `SSP_LAST_TICK_LEAD : `SSP_LAST_TICK_TRAIL;

   always_comb
   begin
      stat_rd = `SSP_STAT_RST;
      stat_rd[`SSP_STAT_SMP] = smp_r;
      stat_rd[`SSP_STAT_CKE] = cke_r;
      stat_rd[`SSP_STAT_BF] = bf_r;
   end

   // Core next state
   always_comb
   begin
      ctl_nxt = ctl_r;
      smp_nxt = smp_r;
      cke_nxt = cke_r;
      bf_nxt = bf_r;
      xbuf_nxt = xbuf_r;
      shreg_nxt = shreg_r;
      sck_nxt = sck_r;
      sdo_nxt = sdo_r;
      state_nxt = state_r;
      tick_cnt_nxt = tick_cnt_r;
      bitcnt_nxt = bitcnt_r;
      irq_nxt = 1'b0;
      in_valid = 1'b0;
      in_data = shreg_r;
      sck_q_nxt = sck_s;
      mrx_nxt = mrx_r;
      msh_nxt = '0;
      mov_nxt = '0;
      mdone_nxt = '0;
      if (master)
      begin
         msh_nxt = {msh_r[`SSP_SDI_LAT-2:0], 1'b0};
         mov_nxt = {mov_r[`SSP_SDI_LAT-2:0], 1'b0};
         mdone_nxt = {mdone_r[`SSP_SDI_LAT-2:0], 1'b0};
      end
      div_nxt = (tick || state_r != ST_SHIFT) ? 6'h00 : div_r + 6'h01;
      if (wr_ctl)
         ctl_nxt = pwdata[7:0];
      if (wr_stat)
      begin
         smp_nxt = pwdata[`SSP_STAT_SMP];
         cke_nxt = pwdata[`SSP_STAT_CKE];
      end
      if (rd_buf)
         bf_nxt = 1'b0;
      if (wr_buf)
      begin
         if (busy)
            ctl_nxt[`SSP_CTL_WRITE_COLLISION_FLAG] = 1'b1;
         else
         begin
            shreg_nxt = pwdata[7:0];
            sdo_nxt = pwdata[7];
            if (master)
               state_nxt = ST_WAIT;
         end
      end
      case (state_r)
         ST_IDLE:
            tick_cnt_nxt = 5'h00;
         ST_WAIT:
            if (in_ready)
               state_nxt = ST_SHIFT;
         ST_SHIFT:
            if (tick)
            begin
               if (tick_cnt_r < `SSP_TICKS)
                  sck_nxt = !sck_r;
               tick_cnt_nxt = tick_cnt_r + 5'h01;
               if (stable)
               begin
                  shreg_nxt = {shreg_r[6:0], sdi_s};
                  msh_nxt[0] = 1'b1;
               end
               else
               begin
                  sdo_nxt = shreg_r[7];
                  if (smp_r && tick_cnt_r != 5'h00)
                     mov_nxt[0] = 1'b1;
               end
               if (tick_cnt_r == last_tick)
               begin
                  mdone_nxt[0] = 1'b1;
                  state_nxt = ST_IDLE;
               end
            end
         default:
            state_nxt = ST_IDLE;
      endcase
      // Input reaches us through the synchroniser, so master capture lags the clock edge
      if (msh_r[`SSP_SDI_LAT-1])
         mrx_nxt = {mrx_r[6:0], sdi_s};
      if (mov_r[`SSP_SDI_LAT-1])
         mrx_nxt[0] = sdi_s;
      if (mdone_r[`SSP_SDI_LAT-1] && master)
      begin
         in_valid = 1'b1;
         in_data = mrx_nxt;
      end
      if (slave && !ss_hold && sedge)
      begin
         if (stable)
         begin
            shreg_nxt = {shreg_r[6:0], sdi_s};
            bitcnt_nxt = bitcnt_r + 3'h1;
            if (bitcnt_r == `SSP_LAST_BIT)
            begin
               if (in_ready)
               begin
                  in_valid = 1'b1;
                  in_data = shreg_nxt;
               end
               else
                  ctl_nxt[`SSP_CTL_OV] = 1'b1;
            end
         end
         else
            sdo_nxt = shreg_r[7];
      end
      if (out_valid && out_ready)
      begin
         if (bf_r && slave)
            ctl_nxt[`SSP_CTL_OV] = 1'b1;
         else
         begin
            xbuf_nxt = out_data;
            bf_nxt = 1'b1;
            irq_nxt = 1'b1;
         end
      end
      if (!en || !master)
         state_nxt = ST_IDLE;
      if (!slave || ss_hold)
         bitcnt_nxt = 3'h0;
      if (state_r != ST_SHIFT)
         sck_nxt = clock_idle_polarity;
      own_nxt = en;
      sck_oe_nxt = master;
      sdo_oe_nxt = (master || slave) && !ss_hold;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctl_r <= `SSP_CTL_RST;
         smp_r <= STAT_RST[`SSP_STAT_SMP];
         cke_r <= STAT_RST[`SSP_STAT_CKE];
         bf_r <= 1'b0;
         xbuf_r <= 8'h00;
         shreg_r <= 8'h00;
         sck_r <= 1'b0;
         sdo_r <= 1'b0;
         sck_oe_r <= 1'b0;
         sdo_oe_r <= 1'b0;
         own_r <= 1'b0;
         irq_r <= 1'b0;
         sck_q_r <= 1'b0;
         state_r <= ST_IDLE;
         tick_cnt_r <= 5'h00;
         div_r <= 6'h00;
         bitcnt_r <= 3'h0;
         mrx_r <= 8'h00;
         msh_r <= '0;
         mov_r <= '0;
         mdone_r <= '0;
      end
      else
      begin
         ctl_r <= ctl_nxt;
         smp_r <= smp_nxt;
         cke_r <= cke_nxt;
         bf_r <= bf_nxt;
         xbuf_r <= xbuf_nxt;
         shreg_r <= shreg_nxt;
         sck_r <= sck_nxt;
         sdo_r <= sdo_nxt;
         sck_oe_r <= sck_oe_nxt;
         sdo_oe_r <= sdo_oe_nxt;
         own_r <= own_nxt;
         irq_r <= irq_nxt;
         sck_q_r <= sck_q_nxt;
         state_r <= state_nxt;
         tick_cnt_r <= tick_cnt_nxt;
         div_r <= div_nxt;
         bitcnt_r <= bitcnt_nxt;
         mrx_r <= mrx_nxt;
         msh_r <= msh_nxt;
         mov_r <= mov_nxt;
         mdone_r <= mdone_nxt;
      end
   end

   // APB answer: one access cycle, data captured in setup
   always_comb
   begin
      pready_nxt = setup;
      pslverr_nxt = setup && !mapped;
      prdata_nxt = '0;
      if (setup && !pwrite)
      begin
         if (addr_is(paddr, `SSP_OFF_CTL))
            prdata_nxt[7:0] = ctl_r;
         else if (addr_is(paddr, `SSP_OFF_STAT))
            prdata_nxt[7:0] = stat_rd;
         else if (addr_is(paddr, `SSP_OFF_BUF))
            prdata_nxt[7:0] = xbuf_r;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
      end
      else
      begin
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign prdata = prdata_r;
   assign sck_out = sck_r;
   assign sck_oe = sck_oe_r;
   assign sdo_out = sdo_r;
   assign sdo_oe = sdo_oe_r;
   assign port_pins_owned = own_r;
   assign port_interrupt_flag = irq_r;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_write_collision_flag_set;
      wr_buf && busy |=> ctl_r[`SSP_CTL_WRITE_COLLISION_FLAG];
   endproperty
   a_write_collision_flag_set: assert property (p_write_collision_flag_set)
      else $error("Collision flag not set");
   property p_ov_drop;
      out_valid && out_ready && bf_r && slave |=> ctl_r[`SSP_CTL_OV] && $stable(xbuf_r);
   endproperty
   a_ov_drop: assert property (p_ov_drop)
      else $error("Overflow not flagged or byte not dropped");
   property p_ov_master;
      $rose(ctl_r[`SSP_CTL_OV]) |-> $past(slave) || $past(wr_ctl);
   endproperty
   a_ov_master: assert property (p_ov_master)
      else $error("Overflow set outside slave operation");
   property p_start;
      master && state_r == ST_IDLE && !wr_buf |=> state_r == ST_IDLE;
   endproperty
   a_start: assert property (p_start)
      else $error("Transfer started without buffer write");
   property p_off;
      !en |=> !sck_oe && !sdo_oe && !port_pins_owned;
   endproperty
   a_off: assert property (p_off)
      else $error("Pins driven while port disabled");
   property p_idle;
      state_r != ST_SHIFT |=> sck_out == $past(clock_idle_polarity);
   endproperty
   a_idle: assert property (p_idle)
      else $error("Clock not at idle level");
   property p_div4;
      tick && ctl_r[`SSP_CTL_MODE] == `SSP_MODE_M4 && tick_cnt_r < last_tick && !wr_ctl
         |=> !tick ##1 tick;
   endproperty
   a_div4: assert property (p_div4)
      else $error("Divide by four tick spacing wrong");
   property p_ss_hold;
      ss_hold |=> bitcnt_r == 3'h0 && !sdo_oe;
   endproperty
   a_ss_hold: assert property (p_ss_hold)
      else $error("Slave not held by slave select");
   property p_bf_clear;
      rd_buf |=> !bf_r;
   endproperty
   a_bf_clear: assert property (p_bf_clear)
      else $error("Buffer full not cleared by read");
   property p_load;
      out_valid && out_ready && !bf_r
         |=> bf_r && port_interrupt_flag && xbuf_r == $past(out_data);
   endproperty
   a_load: assert property (p_load)
      else $error("Received byte not loaded");

   c_master_done: cover property (state_r == ST_SHIFT ##1 state_r == ST_IDLE);
   c_slave_byte: cover property (slave && in_valid);
   c_overflow: cover property ($rose(ctl_r[`SSP_CTL_OV]));
endmodule : ssp_spi
`default_nettype wire

//--- test/ssp_peer.sv
// SPI peer: slave for master-mode tests, master for slave-mode tests
`timescale 1ns/1ps
`default_nettype none
module ssp_peer
(
   input wire logic clk,
   input wire logic clock_idle_polarity,
   input wire logic cke,
   input wire logic sck_out,
   input wire logic sck_oe,
   input wire logic sdo_out,
   output logic sck_in,
   output logic sdi_in,
   output logic ss_n_in
);
   logic [7:0] tx;
   logic [7:0] rx;
   int ns;
   int away;
   initial
   begin
      sck_in = 1'b0;
      sdi_in = 1'b1;
      ss_n_in = 1'b1;
      tx = 8'h00;
      rx = 8'h00;
      ns = 0;
      away = 0;
   end
   task load(input logic [7:0] b);
      tx = b;
      rx = 8'h00;
      ns = 0;
      away = 0;
      sdi_in <= b[7];
   endtask : load
   // Slave role: capture on the stable edge, shift out on the other, MSB first
   always @(sck_out)
      if (sck_oe)
      begin
         if (sck_out == (clock_idle_polarity ^ cke))
         begin
            rx = {rx[6:0], sdo_out};
            ns++;
         end
         else if (ns < 8)
            sdi_in <= tx[7-ns];
         else
            sdi_in <= ~sdi_in;
      end
   // Time the clock spends away from its idle level
   always @(posedge clk)
      if (sck_oe && sck_out != clock_idle_polarity)
         away++;
   // Master role, idle-low clock, data stable on rising edge; clock still between frames
   task mxfer(input logic [7:0] b, input logic sel);
      int i;
      if (sel)
         ss_n_in <= 1'b0;
      rx = 8'h00;
      for (i = 7; i >= 0; i--)
      begin
         sdi_in <= b[i];
         repeat (10) @(posedge clk);
         sck_in <= 1'b1;
         repeat (10) @(posedge clk);
         rx = {rx[6:0], sdo_out};
         sck_in <= 1'b0;
      end
      repeat (10) @(posedge clk);
      sdi_in <= ~b[0];
      ss_n_in <= 1'b1;
   endtask : mxfer
endmodule : ssp_peer
`default_nettype wire

//--- test/tb_top.sv
// Testbench for the SPI-mode serial port
`timescale 1ns/1ps
`default_nettype none
`include "ssp_params.svh"
module tb_top;
   import ssp_pkg::*;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic tick = 1'b0;
   logic sck_in, sck_out, sck_oe, sdi_in, sdo_out, sdo_oe, ss_n_in, owned, irq, clock_idle_polarity, cke;
   logic [`SSP_AW-1:0] paddr;
   logic [1:0] tcnt = 2'h0;
   ssp_word_t pwdata, prdata, rd;
   int miscompares, compares;
   int irqs = 0;
   ssp_spi dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .sdi_in(sdi_in),
      .sdo_out(sdo_out), .sdo_oe(sdo_oe), .ss_n_in(ss_n_in), .timer_two_tick(tick),
      .port_pins_owned(owned), .port_interrupt_flag(irq));
   ssp_peer peer (.clk(clk), .clock_idle_polarity(clock_idle_polarity), .cke(cke), .sck_out(sck_out), .sck_oe(sck_oe),
      .sdo_out(sdo_out), .sck_in(sck_in), .sdi_in(sdi_in), .ss_n_in(ss_n_in));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Timer pulse every fourth cycle; byte-loaded pulses counted
   always @(posedge clk)
   begin
      tcnt <= tcnt + 2'h1;
      tick <= (tcnt == 2'h3);
      if (irq === 1'b1)
         irqs++;
   end
   task chk(input string n, input ssp_word_t e, input ssp_word_t g);
      compares++;
      if (g !== e)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task tally_and_finish;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   task apb(input logic w, input logic [`SSP_AW-1:0] a, input ssp_word_t d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20)
      begin
         miscompares++;
         tally_and_finish();
      end
   endtask : apb
   task wait_bit(input logic [`SSP_AW-1:0] a, input int b);
      int i;
      for (i = 0; i < 400; i++)
      begin
         apb(1'b0, a, 32'h0);
         if (rd[b] === 1'b1)
            break;
      end
      chk("wait_bit", 32'h1, {31'h0, rd[b]});
      if (i == 400)
         tally_and_finish();
   endtask : wait_bit
   task t_reset;
      apb(1'b0, `SSP_OFF_CTL, 32'h0);
      chk("control", {24'h0, `SSP_CTL_RST}, rd);
      apb(1'b0, `SSP_OFF_STAT, 32'h0);
      chk("status", {24'h0, `SSP_STAT_RST}, rd);
      apb(1'b1, 12'h00C, 32'h0000_00FF);
      chk("unmapped_err", 32'h1, {31'h0, err});
      chk("pins_owned", 32'h0, {31'h0, owned});
      $display("test reset done");
   endtask : t_reset
   task t_master(input logic [3:0] m, input logic p, input logic e, input int half,
      input ssp_byte_t tx, input ssp_byte_t prx, input logic s);
      int n0;
      clock_idle_polarity = p;
      cke = e;
      apb(1'b1, `SSP_OFF_CTL, {24'h0, 3'b001, p, m});
      apb(1'b1, `SSP_OFF_STAT, {24'h0, s, e, 6'h00});
      peer.load(prx);
      n0 = irqs;
      apb(1'b1, `SSP_OFF_BUF, {24'h0, tx});
      apb(1'b1, `SSP_OFF_BUF, 32'h0000_00FF);
      wait_bit(`SSP_OFF_STAT, `SSP_STAT_BF);
      chk("sck_idle", {31'h0, p}, {31'h0, sck_out});
      chk("pins_owned", 32'h1, {31'h0, owned});
      chk("irq_count", n0 + 1, irqs);
      chk("peer_rx", {24'h0, tx}, {24'h0, peer.rx});
      chk("sck_away", 8 * half, peer.away);
      apb(1'b0, `SSP_OFF_BUF, 32'h0);
      chk("buffer", {24'h0, prx}, rd);
      apb(1'b0, `SSP_OFF_STAT, 32'h0);
      chk("bf_clear", 32'h0, {31'h0, rd[`SSP_STAT_BF]});
      apb(1'b0, `SSP_OFF_CTL, 32'h0);
      chk("flags", {24'h0, 3'b101, p, m}, rd);
      apb(1'b1, `SSP_OFF_CTL, {24'h0, 3'b001, p, m});
      apb(1'b0, `SSP_OFF_CTL, 32'h0);
      chk("flag_clear", {24'h0, 3'b001, p, m}, rd);
      $display("test master mode %0d done", m);
   endtask : t_master
   task t_slave;
      clock_idle_polarity = 1'b0;
      cke = 1'b1;
      apb(1'b1, `SSP_OFF_CTL, {24'h0, 4'h2, `SSP_MODE_SSS});
      apb(1'b1, `SSP_OFF_STAT, 32'h0000_0040);
      apb(1'b1, `SSP_OFF_BUF, 32'h0000_0096);
      peer.mxfer(8'h5A, 1'b1);
      wait_bit(`SSP_OFF_STAT, `SSP_STAT_BF);
      chk("slave_tx", 32'h96, {24'h0, peer.rx});
      repeat (4) @(posedge clk);
      chk("sdo_release", 32'h0, {31'h0, sdo_oe});
      chk("sck_not_driven", 32'h0, {31'h0, sck_oe});
      peer.mxfer(8'hC3, 1'b1);
      wait_bit(`SSP_OFF_CTL, `SSP_CTL_OV);
      apb(1'b0, `SSP_OFF_BUF, 32'h0);
      chk("slave_keep", 32'h5A, rd);
      apb(1'b1, `SSP_OFF_CTL, {24'h0, 4'h2, `SSP_MODE_SNS});
      peer.mxfer(8'h81, 1'b0);
      wait_bit(`SSP_OFF_STAT, `SSP_STAT_BF);
      apb(1'b0, `SSP_OFF_BUF, 32'h0);
      chk("slave_nss_rx", 32'h81, rd);
      apb(1'b1, `SSP_OFF_CTL, 32'h0);
      repeat (2) @(posedge clk);
      chk("disabled_pins", 32'h0, {30'h0, owned, sck_oe});
      $display("test slave done");
   endtask : t_slave
   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      clock_idle_polarity = 1'b0;
      cke = 1'b0;
      miscompares = 0;
      compares = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_master(`SSP_MODE_M4, 1'b0, 1'b1, 2, 8'hA5, 8'h3C, 1'b0);
      t_master(`SSP_MODE_M16, 1'b1, 1'b1, 8, 8'h5C, 8'hC1, 1'b1);
      t_master(`SSP_MODE_M64, 1'b0, 1'b0, 32, 8'h81, 8'h7E, 1'b0);
      t_master(`SSP_MODE_MT2, 1'b1, 1'b0, 4, 8'h3B, 8'hD4, 1'b1);
      t_slave();
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
